// ==== rfc_consts.svh ====
`ifndef RFC_CONSTS_SVH
`define RFC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define RFC_ADDR_RESYNC             7'h09
`define RFC_ADDR_FIFO_FLUSH         7'h0A
`define RFC_ADDR_DEVICE_INFORMATION 7'h0F
`define RFC_ADDR_GENERAL_CONFIG     7'h10

// ----------------------------------------------------------------------------
// Command data and general configuration layout
// ----------------------------------------------------------------------------
`define RFC_CMD_DATA          24'h000000
`define RFC_CFG_RESET         24'h000004
`define RFC_CFG_ULP_HI        23
`define RFC_CFG_ULP_LO        22
`define RFC_CFG_RATE_HI       21
`define RFC_CFG_RATE_LO       20
`define RFC_CFG_ENABLE        19
`define RFC_ULP_LEAD_ON       2'h1

// ----------------------------------------------------------------------------
// Device information word (revision, part and serial values are arbitrary)
// ----------------------------------------------------------------------------
`define RFC_DEVICE_INFORMATION_PATTERN      4'h5
`define RFC_DEVICE_INFORMATION_REVISION     4'h1
`define RFC_DEVICE_INFORMATION_PART         4'h7
`define RFC_DEVICE_INFORMATION_SERIAL       12'hA5C

// ----------------------------------------------------------------------------
// Serial frame timing
// ----------------------------------------------------------------------------
`define RFC_HDR_LAST          5'h07
`define RFC_FRAME_LAST        5'h1F

// ----------------------------------------------------------------------------
// Master timing clock derivation from the 32768 Hz reference
// ----------------------------------------------------------------------------
`define RFC_REF_CLOCK_HZ      32768
`define RFC_RATE_FULL         2'h0
`define RFC_RATE_DIV41        2'h3
`define RFC_PHASE_LAST_128    7'h7F
`define RFC_PHASE_LAST_41     7'h28
`define RFC_DROP_A            7'h00
`define RFC_DROP_B            7'h2A
`define RFC_DROP_C            7'h55

`endif

// ==== rfc_pkg.sv ====
package rfc_pkg;

  typedef logic [23:0] rfc_word_t;
  typedef logic [6:0]  rfc_addr_t;

  typedef enum logic [1:0] {
    RFC_ST_IDLE = 2'b01,
    RFC_ST_WAIT = 2'b10
  } rfc_state_t;

endpackage

// ==== rfc_frame_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Finished serial frames out of the link domain, readback state into it
// ----------------------------------------------------------------------------
interface rfc_frame_if;
  import rfc_pkg::*;
  logic      toggle;
  rfc_addr_t addr;
  logic      wr;
  rfc_word_t data;
  rfc_word_t rb_config;
  logic      rb_first_done;

  modport link (output toggle, output addr, output wr, output data,
                input rb_config, input rb_first_done);
  modport core (input toggle, input addr, input wr, input data,
                output rb_config, output rb_first_done);
endinterface

`default_nettype wire

// ==== rfc_master_tick.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "rfc_consts.svh"

module rfc_master_tick import rfc_pkg::*; (
  // Clock, reset, enable
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic       ce_in,
  // Reference clock pin and rate select
  input  wire logic       ref_clock_in,
  input  wire logic [1:0] rate_in,
  // One-cycle master timing tick
  output logic            tick_out
);

  logic       ref_s1, ref_s2, ref_s3;
  logic [6:0] phase, next_phase;
  logic       next_tick;
  logic       ref_edge;
  logic       drop;
  logic       wrap;

  // ----------------------------------------------------------------------------
  // Rate select: every reference edge, or edges dropped by a fixed pattern.
  // ----------------------------------------------------------------------------
  always_comb begin
    ref_edge = ref_s2 & ~ref_s3;
    drop = 1'b0;
    wrap = (phase == `RFC_PHASE_LAST_128);
    if (rate_in == `RFC_RATE_DIV41) begin
      // A phase left above the short period by a rate change wraps at once.
      wrap = (phase >= `RFC_PHASE_LAST_41);
      drop = (phase == `RFC_DROP_A);
    end else if (rate_in != `RFC_RATE_FULL) begin
      drop = (phase == `RFC_DROP_A) | (phase == `RFC_DROP_B) | (phase == `RFC_DROP_C);
    end
    next_phase = phase;
    if (ref_edge) begin
      next_phase = wrap ? 7'h00 : phase + 7'h01;
    end
    next_tick = ref_edge & ~drop;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ref_s1   <= 1'b0;
      ref_s2   <= 1'b0;
      ref_s3   <= 1'b0;
      phase    <= 7'h00;
      tick_out <= 1'b0;
    end else if (ce_in) begin
      ref_s1   <= ref_clock_in;
      ref_s2   <= ref_s1;
      ref_s3   <= ref_s2;
      phase    <= next_phase;
      tick_out <= next_tick;
    end
  end

  tick_from_ref_a: assert property (@(posedge clk_in) disable iff (srst_in)
    $rose(tick_out) |-> $past(ref_s2) && !$past(ref_s3))
    else $error("Master tick without a reference edge.");

  div41_drop_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && ref_edge && rate_in == `RFC_RATE_DIV41 && phase == 7'h00) |=> !tick_out)
    else $error("Divide-by-41 rate did not drop its tick.");

endmodule

`default_nettype wire

// ==== rfc_spi_link.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "rfc_consts.svh"

module rfc_spi_link import rfc_pkg::*; (
  // Serial pins, link clock domain
  input  wire logic   sclk_in,
  input  wire logic   csb_n_in,
  input  wire logic   sdi_in,
  input  wire logic   srst_in,
  output logic        sdo_out,
  output logic        sdo_oe_n_out,
  // Frames to the core
  rfc_frame_if.link   frame_if
);

  logic [4:0]  bit_cnt, next_bit_cnt;
  logic [30:0] shreg, next_shreg;
  rfc_word_t   rd_shift, next_rd_shift;
  logic        rd_phase, next_rd_phase;
  logic        next_sdo;
  rfc_word_t   rb_word;
  rfc_word_t   cfg_s1, cfg_s2;
  logic        fd_s1, fd_s2;
  logic        next_toggle;
  rfc_addr_t   next_addr;
  logic        next_wr;
  rfc_word_t   next_data;

  // ----------------------------------------------------------------------------
  // Shift in address, direction and data; load readback after the header.
  // ----------------------------------------------------------------------------
  always_comb begin
    rb_word = 24'h000000;
    case (shreg[6:0])
      `RFC_ADDR_DEVICE_INFORMATION: rb_word = fd_s2 ? {`RFC_DEVICE_INFORMATION_PATTERN, `RFC_DEVICE_INFORMATION_REVISION,
                                                      `RFC_DEVICE_INFORMATION_PART, `RFC_DEVICE_INFORMATION_SERIAL}
                                                    : 24'h000000;
      `RFC_ADDR_GENERAL_CONFIG:     rb_word = cfg_s2;
      default:                      rb_word = 24'h000000;
    endcase
    next_bit_cnt  = bit_cnt + 5'h01;
    next_shreg    = {shreg[29:0], sdi_in};
    next_rd_phase = rd_phase;
    next_rd_shift = {rd_shift[22:0], 1'b0};
    if (bit_cnt == `RFC_HDR_LAST) begin
      next_rd_phase = sdi_in;
      next_rd_shift = sdi_in ? rb_word : 24'h000000;
    end
    next_sdo = rd_shift[23];
  end

  always_ff @(posedge sclk_in or posedge csb_n_in) begin
    if (csb_n_in) begin
      bit_cnt  <= 5'h00;
      shreg    <= 31'h00000000;
      rd_shift <= 24'h000000;
      rd_phase <= 1'b0;
    end else begin
      bit_cnt  <= next_bit_cnt;
      shreg    <= next_shreg;
      rd_shift <= next_rd_shift;
      rd_phase <= next_rd_phase;
    end
  end

  always_ff @(negedge sclk_in or posedge csb_n_in) begin
    if (csb_n_in) begin
      sdo_out <= 1'b0;
    end else begin
      sdo_out <= next_sdo;
    end
  end

  assign sdo_oe_n_out = ~(rd_phase & ~csb_n_in);

  // ----------------------------------------------------------------------------
  // Hold the finished frame and flag it by a toggle on the 32nd edge.
  // ----------------------------------------------------------------------------
  always_comb begin
    next_toggle = frame_if.toggle;
    next_addr   = frame_if.addr;
    next_wr     = frame_if.wr;
    next_data   = frame_if.data;
    if (!csb_n_in && bit_cnt == `RFC_FRAME_LAST) begin
      next_toggle = ~frame_if.toggle;
      next_addr   = shreg[30:24];
      next_wr     = ~shreg[23];
      next_data   = {shreg[22:0], sdi_in};
    end
  end

  always_ff @(posedge sclk_in or posedge srst_in) begin
    if (srst_in) begin
      frame_if.toggle <= 1'b0;
      frame_if.addr   <= 7'h00;
      frame_if.wr     <= 1'b0;
      frame_if.data   <= 24'h000000;
      cfg_s1          <= 24'h000000;
      cfg_s2          <= 24'h000000;
      fd_s1           <= 1'b0;
      fd_s2           <= 1'b0;
    end else begin
      frame_if.toggle <= next_toggle;
      frame_if.addr   <= next_addr;
      frame_if.wr     <= next_wr;
      frame_if.data   <= next_data;
      cfg_s1          <= frame_if.rb_config;
      cfg_s2          <= cfg_s1;
      fd_s1           <= frame_if.rb_first_done;
      fd_s2           <= fd_s1;
    end
  end

  device_information_pattern_a: assert property (@(posedge sclk_in) disable iff (csb_n_in)
    (bit_cnt == `RFC_HDR_LAST && sdi_in && shreg[6:0] == `RFC_ADDR_DEVICE_INFORMATION && fd_s2)
    |=> rd_shift[23:20] == 4'h5 && rd_phase)
    else $error("Information check pattern wrong.");

  device_information_revision_a: assert property (@(posedge sclk_in) disable iff (csb_n_in)
    (bit_cnt == `RFC_HDR_LAST && sdi_in && shreg[6:0] == `RFC_ADDR_DEVICE_INFORMATION && fd_s2)
    |=> rd_shift[19:16] == `RFC_DEVICE_INFORMATION_REVISION ##4 rd_shift[23:20] == `RFC_DEVICE_INFORMATION_REVISION)
    else $error("Revision field wrong or not shifted.");

  first_read_a: assert property (@(posedge sclk_in) disable iff (csb_n_in)
    (bit_cnt == `RFC_HDR_LAST && sdi_in && !fd_s2 && shreg[6:0] == `RFC_ADDR_DEVICE_INFORMATION)
    |=> rd_shift == 24'h000000)
    else $error("First command returned data.");

  cmd_read_zero_a: assert property (@(posedge sclk_in) disable iff (csb_n_in)
    (bit_cnt == `RFC_HDR_LAST && sdi_in && (shreg[6:0] == `RFC_ADDR_RESYNC ||
     shreg[6:0] == `RFC_ADDR_FIFO_FLUSH)) |=> rd_shift == 24'h000000)
    else $error("Command address read returned data.");

endmodule

`default_nettype wire

// ==== rfc_cmd_top.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "rfc_consts.svh"

// Functional notes
// - Resync write fires on next master tick.
// - Resync acts only on all-zero data.
// - Resync resets channel and beat-interval logic.
// - Resync clears FIFO, filters to midscale.
// - Resync leaves configuration registers unchanged.
// - Configuration changes need resync to restart cleanly.
// - Flush write resets FIFO, recording continues.
// - Flush acts only on all-zero data.
// - Flush leaves channel and beat logic alone.
// - Information top nibble is alternating pattern.
// - Information bits 19:16 hold revision.
// - Part nibble then non-unique serial nibbles.
// - First command information read is invalid.
// - Channel disabled selects one of two low-power modes.
// - General configuration selects master clock rate.
// - Master timing derives from 32768 Hz reference.

module rfc_cmd_top import rfc_pkg::*; (
  // Core clock, reset and enable
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        ce_in,
  // Reference clock pin
  input  wire logic        reference_clock_in,
  // Serial register port
  input  wire logic        spi_sclk_in,
  input  wire logic        spi_csb_n_in,
  input  wire logic        spi_sdi_in,
  output logic             spi_sdo_out,
  output logic             spi_sdo_oe_n_out,
  // Restart controls to the acquisition path
  output logic             chan_reset_out,
  output logic             beat_reset_out,
  output logic             filter_midscale_out,
  output logic             fifo_clear_out,
  // Timing and configuration state
  output logic             master_tick_out,
  output logic [1:0]       master_rate_out,
  output logic             channel_enable_out,
  output logic             chan_power_down_out,
  output logic             ulp_lead_on_out,
  output logic [23:0]      general_config_out
);

  rfc_frame_if frame_if ();

  logic       tog_s1, tog_s2, tog_s3;
  logic       frame_ev;
  logic       cmd_data_zero;
  logic       cmd_resync;
  logic       cmd_flush;
  logic       cfg_wr;
  logic       fire;
  rfc_state_t state, next_state;
  rfc_word_t  general_config, next_general_config;
  logic       first_done, next_first_done;
  logic       next_chan_reset;
  logic       next_fifo_clear;
  logic       master_tick;

  // ----------------------------------------------------------------------------
  // Serial link and master timing
  // ----------------------------------------------------------------------------
  rfc_spi_link u_link (
    .sclk_in      (spi_sclk_in),
    .csb_n_in     (spi_csb_n_in),
    .sdi_in       (spi_sdi_in),
    .srst_in      (srst_in),
    .sdo_out      (spi_sdo_out),
    .sdo_oe_n_out (spi_sdo_oe_n_out),
    .frame_if     (frame_if.link)
  );

  rfc_master_tick u_tick (
    .clk_in       (clk_in),
    .srst_in      (srst_in),
    .ce_in        (ce_in),
    .ref_clock_in (reference_clock_in),
    .rate_in      (general_config[`RFC_CFG_RATE_HI:`RFC_CFG_RATE_LO]),
    .tick_out     (master_tick)
  );

  assign frame_if.rb_config     = general_config;
  assign frame_if.rb_first_done = first_done;

  // ----------------------------------------------------------------------------
  // Frame event crossing; the held frame is stable for a whole frame after.
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
    end else if (ce_in) begin
      tog_s1 <= frame_if.toggle;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
    end
  end

  // ----------------------------------------------------------------------------
  // Command decode.
  // ----------------------------------------------------------------------------
  always_comb begin
    frame_ev      = ce_in & (tog_s2 ^ tog_s3);
    cmd_data_zero = (frame_if.data == `RFC_CMD_DATA);
    cmd_resync    = frame_ev & frame_if.wr & cmd_data_zero & (frame_if.addr == `RFC_ADDR_RESYNC);
    cmd_flush     = frame_ev & frame_if.wr & cmd_data_zero & (frame_if.addr == `RFC_ADDR_FIFO_FLUSH);
    cfg_wr        = frame_ev & frame_if.wr & (frame_if.addr == `RFC_ADDR_GENERAL_CONFIG);
  end

  // ----------------------------------------------------------------------------
  // Resync waits for the next master tick, then pulses the restart controls.
  // ----------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    fire       = 1'b0;
    case (state)
      RFC_ST_IDLE: begin
        if (cmd_resync) begin
          next_state = RFC_ST_WAIT;
        end
      end
      RFC_ST_WAIT: begin
        if (master_tick) begin
          fire       = 1'b1;
          next_state = cmd_resync ? RFC_ST_WAIT : RFC_ST_IDLE;
        end
      end
      default: begin
        next_state = RFC_ST_IDLE;
      end
    endcase
    next_chan_reset = fire;
    next_fifo_clear = fire | cmd_flush;
  end

  always_comb begin
    next_general_config = general_config;
    if (cfg_wr) begin
      next_general_config = frame_if.data;
    end
    next_first_done = first_done | frame_ev;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state               <= RFC_ST_IDLE;
      general_config      <= `RFC_CFG_RESET;
      first_done          <= 1'b0;
      chan_reset_out      <= 1'b0;
      fifo_clear_out      <= 1'b0;
    end else if (ce_in) begin
      state               <= next_state;
      general_config      <= next_general_config;
      first_done          <= next_first_done;
      chan_reset_out      <= next_chan_reset;
      fifo_clear_out      <= next_fifo_clear;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------------
  assign beat_reset_out      = chan_reset_out;
  assign filter_midscale_out = chan_reset_out;
  assign master_tick_out     = master_tick;
  assign master_rate_out     = general_config[`RFC_CFG_RATE_HI:`RFC_CFG_RATE_LO];
  assign channel_enable_out  = general_config[`RFC_CFG_ENABLE];
  assign chan_power_down_out = ~general_config[`RFC_CFG_ENABLE];
  assign ulp_lead_on_out     = ~general_config[`RFC_CFG_ENABLE] &
                               (general_config[`RFC_CFG_ULP_HI:`RFC_CFG_ULP_LO] == `RFC_ULP_LEAD_ON);
  assign general_config_out  = general_config;

  // ----------------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence resync_accepted;
    cmd_resync && state == RFC_ST_IDLE;
  endsequence

  sequence resync_fired;
    state == RFC_ST_WAIT && master_tick && ce_in ##1 chan_reset_out;
  endsequence

  resync_on_tick_a: assert property ($rose(chan_reset_out) |-> $past(master_tick) && $past(state) == RFC_ST_WAIT)
    else $error("Restart pulse without a master tick.");

  resync_pending_a: assert property (resync_accepted |=> state == RFC_ST_WAIT && !chan_reset_out)
    else $error("Resync did not wait for the master tick.");

  resync_fire_a: assert property (resync_fired |-> fifo_clear_out && state == RFC_ST_IDLE || !ce_in)
    else $error("Resync fired without clearing the FIFO.");

  nonzero_resync_a: assert property ((frame_ev && frame_if.wr && frame_if.addr == `RFC_ADDR_RESYNC &&
    frame_if.data != 24'h000000 && state == RFC_ST_IDLE) |=> state == RFC_ST_IDLE)
    else $error("Resync accepted with nonzero data.");

  chan_beat_tied_a: assert property (chan_reset_out |-> beat_reset_out && filter_midscale_out)
    else $error("Channel and beat-interval resets differ.");

  config_kept_a: assert property ((state == RFC_ST_WAIT && master_tick && !cfg_wr && ce_in)
    |=> general_config == $past(general_config) && chan_reset_out)
    else $error("Configuration changed by resync.");

  flush_clears_a: assert property (cmd_flush |=> fifo_clear_out)
    else $error("Flush did not clear the FIFO.");

  flush_nonzero_a: assert property ((frame_ev && frame_if.wr && frame_if.addr == `RFC_ADDR_FIFO_FLUSH &&
    frame_if.data != 24'h000000 && !fire) |=> !fifo_clear_out)
    else $error("Flush accepted with nonzero data.");

  flush_no_chan_a: assert property ((cmd_flush && state == RFC_ST_IDLE) |=> !chan_reset_out ##1 !chan_reset_out)
    else $error("Flush disturbed the channel.");

  low_power_a: assert property (!general_config[`RFC_CFG_ENABLE] |-> chan_power_down_out &&
    ulp_lead_on_out == (general_config[23:22] == 2'h1))
    else $error("Low-power mode select wrong.");

endmodule

`default_nettype wire

// ==== rfc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Host serial master: mode 0, serial clock idles low and runs only in frames
// ----------------------------------------------------------------------------
module rfc_host_model (
  // Serial pins toward the device
  output logic      sclk_out,
  output logic      csb_n_out,
  output logic      sdi_out,
  input  wire logic sdo_in,
  input  wire logic sdo_oe_n_in
);
  initial begin
    sclk_out  = 1'b0;
    csb_n_out = 1'b1;
    sdi_out   = 1'b0;
  end

  // A read bit taken while the device does not drive the line is unknown.
  task automatic xfer(input logic [6:0] addr, input logic rd, input logic [23:0] wdata,
                      output logic [23:0] rdata);
    logic [31:0] frame;
    frame     = {addr, rd, wdata};
    rdata     = 24'h000000;
    csb_n_out = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      sdi_out = frame[i];
      #32;
      if (i < 24) begin
        rdata[i] = (sdo_oe_n_in === 1'b0) ? sdo_in : 1'bx;
      end
      sclk_out = 1'b1;
      #32;
      sclk_out = 1'b0;
    end
    #32;
    csb_n_out = 1'b1;
    sdi_out   = ~sdi_out;
    #160;
  endtask
endmodule

`default_nettype wire

// ==== rfc_cmd_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "rfc_consts.svh"

module rfc_cmd_tb_top;
  import rfc_pkg::*;
  logic        clk_in             = 1'b0;
  logic        srst_in            = 1'b1;
  logic        ce_in              = 1'b1;
  logic        reference_clock_in = 1'b0;
  logic        sclk;
  logic        csb_n;
  logic        sdi;
  logic        sdo;
  logic        sdo_oe_n;
  logic        chan_rst;
  logic        beat_rst;
  logic        filt_mid;
  logic        fifo_clr;
  logic        tick;
  logic [1:0]  rate;
  logic        ch_en;
  logic        pwr_dn;
  logic        ulp;
  rfc_word_t   gen_cfg;
  logic [3:0]  exp_q[$];
  logic [3:0]  exp_v;
  logic        prev_tick = 1'b0;
  logic [31:0] rng       = 32'h580F;
  int          miscompares = 0;
  int          n_checks    = 0;
  int          n_ticks     = 0;

  always #2 clk_in = ~clk_in;
  always #1000 reference_clock_in = ~reference_clock_in;

  rfc_cmd_top dut_u (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in),
    .reference_clock_in(reference_clock_in), .spi_sclk_in(sclk), .spi_csb_n_in(csb_n),
    .spi_sdi_in(sdi), .spi_sdo_out(sdo), .spi_sdo_oe_n_out(sdo_oe_n), .chan_reset_out(chan_rst),
    .beat_reset_out(beat_rst), .filter_midscale_out(filt_mid), .fifo_clear_out(fifo_clr),
    .master_tick_out(tick), .master_rate_out(rate), .channel_enable_out(ch_en),
    .chan_power_down_out(pwr_dn), .ulp_lead_on_out(ulp), .general_config_out(gen_cfg));

  rfc_host_model host_u (.sclk_out(sclk), .csb_n_out(csb_n), .sdi_out(sdi), .sdo_in(sdo),
    .sdo_oe_n_in(sdo_oe_n));

  // --------------------------------------------------------------------------
  // Checking and host tasks
  // --------------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input rfc_addr_t a, input rfc_word_t d);
    rfc_word_t r;
    host_u.xfer(a, 1'b0, d, r);
  endtask

  task automatic rd(input rfc_addr_t a, input rfc_word_t exp);
    rfc_word_t r;
    host_u.xfer(a, 1'b1, 24'h000000, r);
    check(32'(r), 32'(exp));
  endtask

  task automatic drain();
    for (int i = 0; i < 3000 && exp_q.size() != 0; i++) begin
      @(negedge clk_in);
    end
    check(32'(exp_q.size()), 32'h0);
  endtask

  task automatic count_ticks(input rfc_word_t cfg, input int edges, input int exp);
    wr(`RFC_ADDR_GENERAL_CONFIG, cfg);
    repeat (2) @(posedge reference_clock_in);
    repeat (10) @(negedge clk_in);
    n_ticks = 0;
    repeat (edges) @(posedge reference_clock_in);
    repeat (10) @(negedge clk_in);
    check(32'(n_ticks), 32'(exp));
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Output watcher: every restart pulse consumes the oldest expectation
  // --------------------------------------------------------------------------
  always @(negedge clk_in) begin
    if (!srst_in && (chan_rst || fifo_clr)) begin
      exp_v = (exp_q.size() != 0) ? exp_q.pop_front() : 4'h0;
      check(32'({chan_rst, beat_rst, filt_mid, fifo_clr}), 32'(exp_v));
      if (chan_rst === 1'b1) begin
        check(32'(prev_tick), 32'h1);
      end
    end
    prev_tick = tick;
    if (tick === 1'b1) begin
      n_ticks++;
    end
  end

  initial begin
    #300000;
    miscompares++;
    wrap_up();
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (4) @(negedge clk_in);
    srst_in = 1'b0;
    @(negedge clk_in);
    check(32'(gen_cfg), 32'h000004);
    check(32'({pwr_dn, ulp, rate}), 32'h8);
    rd(`RFC_ADDR_DEVICE_INFORMATION, 24'h000000);
    rd(`RFC_ADDR_DEVICE_INFORMATION, {4'h5, `RFC_DEVICE_INFORMATION_REVISION, `RFC_DEVICE_INFORMATION_PART, `RFC_DEVICE_INFORMATION_SERIAL});
    rd(`RFC_ADDR_RESYNC, 24'h000000);
    rd(`RFC_ADDR_FIFO_FLUSH, 24'h000000);
    for (int k = 0; k < 6; k++) begin
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      wr(k[0] ? `RFC_ADDR_FIFO_FLUSH : `RFC_ADDR_RESYNC, rng[23:0] | 24'h000001);
    end
    wr(`RFC_ADDR_GENERAL_CONFIG, 24'h600004);
    repeat (10) @(negedge clk_in);
    check(32'({gen_cfg, rate, ch_en, pwr_dn, ulp}), {24'h600004, 5'b10011});
    rd(`RFC_ADDR_GENERAL_CONFIG, 24'h600004);
    wr(`RFC_ADDR_GENERAL_CONFIG, 24'h480004);
    repeat (10) @(negedge clk_in);
    check(32'({rate, ch_en, pwr_dn, ulp}), 32'h04);
    repeat (3) @(posedge tick);
    exp_q.push_back(4'h1);
    wr(`RFC_ADDR_FIFO_FLUSH, `RFC_CMD_DATA);
    drain();
    exp_q.push_back(4'hF);
    wr(`RFC_ADDR_RESYNC, `RFC_CMD_DATA);
    drain();
    check(32'(gen_cfg), 32'h480004);
    count_ticks(24'h080004, 20, 20);
    count_ticks(24'h380004, 41, 40);
    wrap_up();
  end
endmodule

`default_nettype wire
